// *** design/sma_max_addr_sec.v ***
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sma_consts.vh"

// Operation
// - Set-max code right after read-native-max is a plain address set
// - Otherwise the feature value selects the security sub-command
// - Set-password requests one sector and the host supplies it
// - Password kept until reset; set-password only when unlocked
// - Lock enters locked state; only unlock and freeze then accepted
// - Locked state holds until reset, unlock or freeze
// - Unlock takes one sector and compares its password field
// - Unlock mismatch aborts and decrements the attempt counter
// - Attempt counter starts at five, one less per mismatch
// - Counter at zero rejects all unlock until reset
// - Unlock match returns to unlocked, all commands accepted again
// - Freeze enters frozen; address, password, lock, unlock then rejected
// - Plain address set aborted while locked or frozen
module sma_max_addr_sec #(
  parameter SECTOR_WORDS = `SMA_SECTOR_WORDS,
  parameter ATTEMPTS     = `SMA_ATTEMPTS_INIT
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  output reg         irq_q,
  output reg         max_addr_set_q
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [2:0] ST_UNLK = 3'b001;
  localparam [2:0] ST_LOCK = 3'b010;
  localparam [2:0] ST_FRZ  = 3'b100;
  localparam [1:0] CF_IDLE = 2'b01;
  localparam [1:0] CF_XFER = 2'b10;
  localparam [31:0] LAST_FULL = SECTOR_WORDS - 1;
  localparam [7:0]  LAST_WORD = LAST_FULL[7:0];

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [2:0]  lock_q;
  reg  [2:0]  lock_d;
  reg  [1:0]  cfsm_q;
  reg         sub_unlock_q;
  reg  [7:0]  widx_q;
  reg         mism_q;
  reg         native_q;
  reg         abort_q;
  reg         drq_q;
  reg         ev_done_q;
  reg         ev_abort_q;
  reg         ev_drq_q;
  reg         dec_q;
  reg  [7:0]  feature_q;
  reg  [2:0]  int_mask_q;
  reg  [15:0] pw_mem [0:`SMA_PW_WORDS-1];
  reg         rej_d;
  reg         xfer_d;
  reg         max_set_d;
  reg  [31:0] rd_d;
  reg         err_d;
  wire        acc;
  wire        wr_done;
  wire        cmd_wr;
  wire        data_wr;
  wire        in_pw;
  wire [3:0]  pw_idx;
  wire        word_mis;
  wire        last_word;
  wire [2:0]  attempts;
  wire        att_zero;
  wire [2:0]  int_sts;
  wire [2:0]  int_set;
  wire [7:0]  cmd_code;
  integer     i;

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  assign acc      = psel & penable & ~pready_q;
  assign wr_done  = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign cmd_wr   = wr_done && (paddr == `SMA_OFS_COMMAND);
  assign data_wr  = wr_done && (paddr == `SMA_OFS_DATA);
  assign cmd_code = pwdata[7:0];

  always @* begin
    err_d = 1'b0;
    case (paddr)
      `SMA_OFS_COMMAND:   err_d = pwrite & (cfsm_q != CF_IDLE);
      `SMA_OFS_DATA:      err_d = pwrite & (cfsm_q != CF_XFER);
      `SMA_OFS_FEATURE:   err_d = 1'b0;
      `SMA_OFS_INT_STS:   err_d = 1'b0;
      `SMA_OFS_INT_MASK:  err_d = 1'b0;
      `SMA_OFS_ERROR:     err_d = pwrite;
      `SMA_OFS_STATUS:    err_d = pwrite;
      `SMA_OFS_SEC_STATE: err_d = pwrite;
      default:            err_d = 1'b1;
    endcase
  end

  always @* begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `SMA_OFS_FEATURE:   rd_d[7:0] = feature_q;
      `SMA_OFS_ERROR:     rd_d[`SMA_ERR_ABORTED_BIT] = abort_q;
      `SMA_OFS_STATUS: begin
        rd_d[`SMA_STS_BUSY_BIT]  = 1'b0;
        rd_d[`SMA_STS_READY_BIT] = 1'b1;
        rd_d[`SMA_STS_FAULT_BIT] = 1'b0;
        rd_d[`SMA_STS_DRQ_BIT]   = drq_q;
        rd_d[`SMA_STS_ERR_BIT]   = abort_q;
      end
      `SMA_OFS_SEC_STATE: rd_d[6:0] = {attempts, 1'b0, lock_q};
      `SMA_OFS_INT_STS:   rd_d[2:0] = int_sts;
      `SMA_OFS_INT_MASK:  rd_d[2:0] = int_mask_q;
      default:            rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      if (acc) begin
        pslverr_q <= err_d;
        prdata_q  <= (pwrite | err_d) ? 32'h0000_0000 : rd_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Software controlled registers
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_q  <= `SMA_FEATURE_RST;
      int_mask_q <= `SMA_INT_MASK_RST;
    end else if (wr_done) begin
      if (paddr == `SMA_OFS_FEATURE) begin
        feature_q <= pwdata[7:0];
      end
      if (paddr == `SMA_OFS_INT_MASK) begin
        int_mask_q <= pwdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  always @* begin
    rej_d     = 1'b0;
    xfer_d    = 1'b0;
    max_set_d = 1'b0;
    lock_d    = lock_q;
    if (cmd_code == `SMA_CMD_SET_MAX) begin
      if (native_q) begin
        if (lock_q != ST_UNLK) begin
          rej_d = 1'b1;
        end else begin
          max_set_d = 1'b1;
        end
      end else begin
        case (feature_q)
          `SMA_FEAT_SET_PW: begin
            if (lock_q != ST_UNLK) begin
              rej_d = 1'b1;
            end else begin
              xfer_d = 1'b1;
            end
          end
          `SMA_FEAT_LOCK: begin
            if (lock_q != ST_UNLK) begin
              rej_d = 1'b1;
            end else begin
              lock_d = ST_LOCK;
            end
          end
          `SMA_FEAT_UNLOCK: begin
            if ((lock_q == ST_FRZ) || att_zero) begin
              rej_d = 1'b1;
            end else begin
              xfer_d = 1'b1;
            end
          end
          `SMA_FEAT_FREEZE: begin
            lock_d = ST_FRZ;
          end
          default: begin
            rej_d = 1'b1;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Sector transfer
  // ------------------------------------------------------------
  assign in_pw = (widx_q >= `SMA_PW_FIRST_WORD) &&
                 (widx_q <= `SMA_PW_LAST_WORD);
  assign pw_idx    = widx_q[3:0] - 4'h1;
  assign word_mis  = in_pw && (pwdata[15:0] != pw_mem[pw_idx]);
  assign last_word = (widx_q == LAST_WORD);

  // Password kept until reset or the next set-password sector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `SMA_PW_WORDS; i = i + 1) begin
        pw_mem[i] <= 16'h0000;
      end
    end else if (data_wr && !sub_unlock_q && in_pw) begin
      pw_mem[pw_idx] <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Command sequencer and lock state
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q         <= ST_UNLK;
      cfsm_q         <= CF_IDLE;
      sub_unlock_q   <= 1'b0;
      widx_q         <= 8'h00;
      mism_q         <= 1'b0;
      native_q       <= 1'b0;
      abort_q        <= 1'b0;
      drq_q          <= 1'b0;
      ev_done_q      <= 1'b0;
      ev_abort_q     <= 1'b0;
      ev_drq_q       <= 1'b0;
      dec_q          <= 1'b0;
      max_addr_set_q <= 1'b0;
    end else begin
      ev_done_q      <= 1'b0;
      ev_abort_q     <= 1'b0;
      ev_drq_q       <= 1'b0;
      dec_q          <= 1'b0;
      max_addr_set_q <= 1'b0;
      case (cfsm_q)
        CF_IDLE: begin
          if (cmd_wr) begin
            native_q <= (cmd_code == `SMA_CMD_READ_NATIVE);
            abort_q  <= rej_d;
            lock_q   <= rej_d ? lock_q : lock_d;
            max_addr_set_q <= max_set_d;
            if (xfer_d) begin
              cfsm_q       <= CF_XFER;
              drq_q        <= 1'b1;
              ev_drq_q     <= 1'b1;
              widx_q       <= 8'h00;
              mism_q       <= 1'b0;
              sub_unlock_q <= (feature_q == `SMA_FEAT_UNLOCK);
            end else begin
              ev_done_q  <= 1'b1;
              ev_abort_q <= rej_d;
            end
          end
        end
        CF_XFER: begin
          if (data_wr) begin
            widx_q <= widx_q + 8'h01;
            mism_q <= mism_q | word_mis;
            if (last_word) begin
              cfsm_q    <= CF_IDLE;
              drq_q     <= 1'b0;
              ev_done_q <= 1'b1;
              if (sub_unlock_q) begin
                if (mism_q | word_mis) begin
                  abort_q    <= 1'b1;
                  ev_abort_q <= 1'b1;
                  dec_q      <= 1'b1;
                end else begin
                  lock_q <= ST_UNLK;
                end
              end
            end
          end
        end
        default: begin
          cfsm_q <= CF_IDLE;
          drq_q  <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Attempt counter
  // ------------------------------------------------------------
  sma_attempt_ctr #(
    .WIDTH (3),
    .INIT  (ATTEMPTS[2:0])
  ) u_attempts (
    .pclk    (pclk),
    .presetn (presetn),
    .dec     (dec_q),
    .cnt_q   (attempts),
    .zero    (att_zero)
  );

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  assign int_set = {ev_drq_q, ev_abort_q, ev_done_q};

  genvar g;
  generate
    for (g = 0; g < `SMA_INT_BITS; g = g + 1) begin : g_int
      sma_irq_bit u_bit (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (int_set[g]),
        .clr     (wr_done && (paddr == `SMA_OFS_INT_STS) && pwdata[g]),
        .sts_q   (int_sts[g])
      );
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_sts & int_mask_q);
    end
  end

endmodule // sma_max_addr_sec

`default_nettype wire

// *** design/sma_consts.vh ***
`ifndef SMA_CONSTS_VH
`define SMA_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SMA_OFS_COMMAND    8'h00
`define SMA_OFS_FEATURE    8'h04
`define SMA_OFS_DATA       8'h08
`define SMA_OFS_ERROR      8'h0c
`define SMA_OFS_STATUS     8'h10
`define SMA_OFS_SEC_STATE  8'h14
`define SMA_OFS_INT_STS    8'h18
`define SMA_OFS_INT_MASK   8'h1c

// ------------------------------------------------------------
// Command and feature codes
// ------------------------------------------------------------
`define SMA_CMD_SET_MAX     8'hf9
`define SMA_CMD_READ_NATIVE 8'hf8
`define SMA_FEAT_SET_PW     8'h01
`define SMA_FEAT_LOCK       8'h02
`define SMA_FEAT_UNLOCK     8'h03
`define SMA_FEAT_FREEZE     8'h04

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SMA_ERR_ABORTED_BIT 2
`define SMA_STS_BUSY_BIT    7
`define SMA_STS_READY_BIT   6
`define SMA_STS_FAULT_BIT   5
`define SMA_STS_DRQ_BIT     3
`define SMA_STS_ERR_BIT     0
`define SMA_INT_DONE_BIT    0
`define SMA_INT_ABORT_BIT   1
`define SMA_INT_DRQ_BIT     2
`define SMA_INT_BITS        3

// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define SMA_FEATURE_RST     8'h00
`define SMA_INT_MASK_RST    3'h0
`define SMA_ATTEMPTS_INIT   3'h5
`define SMA_SECTOR_WORDS    256
`define SMA_PW_FIRST_WORD   8'h01
`define SMA_PW_LAST_WORD    8'h10
`define SMA_PW_WORDS        16

`endif

// *** design/sma_irq_bit.v ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Sticky event bit, cleared by writing a one
// ------------------------------------------------------------
module sma_irq_bit (
  input  wire pclk,
  input  wire presetn,
  input  wire set,
  input  wire clr,
  output reg  sts_q
);

  // Set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= 1'b0;
    end else if (set) begin
      sts_q <= 1'b1;
    end else if (clr) begin
      sts_q <= 1'b0;
    end
  end

endmodule // sma_irq_bit

`default_nettype wire

// *** design/sma_attempt_ctr.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sma_consts.vh"

// ------------------------------------------------------------
// Unlock attempt down counter, stops at zero
// ------------------------------------------------------------
module sma_attempt_ctr #(
  parameter       WIDTH = 3,
  parameter [2:0] INIT  = `SMA_ATTEMPTS_INIT
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             dec,
  output reg  [WIDTH-1:0] cnt_q,
  output wire             zero
);

  assign zero = (cnt_q == {WIDTH{1'b0}});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= INIT;
    end else if (dec && !zero) begin
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // sma_attempt_ctr

`default_nettype wire

// *** sim/sma_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sma_consts.vh"

// ------------------------------------------------------------
// Host side APB master
// ------------------------------------------------------------
module sma_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata_q,
  input  wire logic        pready_q,
  input  wire logic        pslverr_q,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 50);
    if (n >= 50) begin
      sma_max_addr_sec_tb.num_errors++;
      sma_max_addr_sec_tb.summarize();
    end
    r = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic cmd(input logic [7:0] f, input logic [7:0] c);
    wr(`SMA_OFS_FEATURE, {24'h0, f});
    wr(`SMA_OFS_COMMAND, {24'h0, c});
  endtask

  task automatic sector(input logic [15:0] pw);
    for (int i = 0; i < `SMA_SECTOR_WORDS; i++)
      wr(`SMA_OFS_DATA, (i >= 1 && i <= 16) ? {16'h0, pw + 16'(i)} : 0);
  endtask
endmodule // sma_host

`default_nettype wire

// *** sim/sma_max_addr_sec_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sma_consts.vh"

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module sma_max_addr_sec_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  input wire logic        irq_q,
  input wire logic        max_addr_set_q
);
  wire fin = psel && penable && pready_q;
  wire rdf = fin && !pwrite;
  wire cmdw = fin && pwrite && paddr == `SMA_OFS_COMMAND
              && pwdata[7:0] == `SMA_CMD_SET_MAX;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("ready held");
  one_wait_a: assert property ($rose(penable) && psel |=> pready_q)
    else $error("ready late");
  err_ready_a: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  ro_write_a: assert property (fin && pwrite
    && paddr == `SMA_OFS_STATUS |-> pslverr_q)
    else $error("status write accepted");
  status_fixed_a: assert property (rdf && paddr == `SMA_OFS_STATUS
    |-> prdata_q[7:5] == 3'b010) else $error("status fixed bits");
  lock_state_a: assert property (rdf && paddr == `SMA_OFS_SEC_STATE
    |-> $onehot(prdata_q[2:0]) && prdata_q[6:4] <= 3'd5)
    else $error("lock state bad");
  set_cause_a: assert property (max_addr_set_q
    |-> $past(cmdw) || $past(cmdw, 2) || $past(cmdw, 3))
    else $error("set pulse without command");
  set_pulse_a: assert property (max_addr_set_q |=> !max_addr_set_q)
    else $error("set pulse long");
  rst_quiet_a: assert property ($rose(presetn)
    |-> !irq_q && !max_addr_set_q && !pready_q) else $error("reset outputs");
endmodule // sma_max_addr_sec_sva

bind sma_max_addr_sec sma_max_addr_sec_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
  .pready_q(pready_q), .pslverr_q(pslverr_q), .irq_q(irq_q),
  .max_addr_set_q(max_addr_set_q)
);

`default_nettype wire

// *** sim/sma_max_addr_sec_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sma_consts.vh"

module sma_max_addr_sec_tb;
  localparam logic [7:0] OK = 8'h40;
  localparam logic [7:0] AB = 8'h41;
  localparam logic [7:0] DQ = 8'h48;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        max_addr_set_q;
  logic [31:0] rv;
  logic        er;
  int          num_errors = 0;
  int          compares = 0;
  int          pulses = 0;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (max_addr_set_q === 1'b1) pulses++;

  sma_max_addr_sec u_sma_max_addr_sec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .irq_q(irq_q),
    .max_addr_set_q(max_addr_set_q)
  );
  sma_host u_sma_host (
    .pclk(pclk), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    u_sma_host.xfer(1'b0, a, 32'h0, rv, er);
  endtask
  task automatic sts(input logic [7:0] e);
    rd(`SMA_OFS_STATUS);
    chk("status", {24'h0, e}, rv & 32'he9);
    rd(`SMA_OFS_ERROR);
    chk("error", {29'h0, e[0], 2'b0}, rv & 32'h4);
  endtask
  task automatic sec(input logic [6:0] e);
    rd(`SMA_OFS_SEC_STATE);
    chk("sec_state", {25'h0, e}, rv & 32'h7f);
  endtask
  task automatic plain_set();
    u_sma_host.cmd(8'h00, `SMA_CMD_READ_NATIVE);
    u_sma_host.cmd(8'h00, `SMA_CMD_SET_MAX);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    sec(7'h51);
    rd(8'h20);
    chk("unmapped", 32'h1, {31'h0, er});
    u_sma_host.xfer(1'b1, `SMA_OFS_STATUS, 32'h0, rv, er);
    chk("ro_write", 32'h1, {31'h0, er});
    u_sma_host.cmd(`SMA_FEAT_SET_PW, `SMA_CMD_SET_MAX);
    sts(DQ);
    u_sma_host.sector(16'h1000);
    sts(OK);
    u_sma_host.cmd(`SMA_FEAT_LOCK, `SMA_CMD_SET_MAX);
    sec(7'h52);
    u_sma_host.cmd(`SMA_FEAT_SET_PW, `SMA_CMD_SET_MAX);
    sts(AB);
    plain_set();
    sts(AB);
    for (int i = 4; i >= 0; i--) begin
      u_sma_host.cmd(`SMA_FEAT_UNLOCK, `SMA_CMD_SET_MAX);
      sts(DQ);
      u_sma_host.sector(16'h2000);
      sts(AB);
      sec({3'(i), 4'h2});
    end
    u_sma_host.cmd(`SMA_FEAT_UNLOCK, `SMA_CMD_SET_MAX);
    sts(AB);
    do_reset();
    sec(7'h51);
    u_sma_host.cmd(`SMA_FEAT_SET_PW, `SMA_CMD_SET_MAX);
    u_sma_host.sector(16'h3000);
    u_sma_host.cmd(`SMA_FEAT_LOCK, `SMA_CMD_SET_MAX);
    u_sma_host.cmd(`SMA_FEAT_UNLOCK, `SMA_CMD_SET_MAX);
    u_sma_host.sector(16'h3000);
    sts(OK);
    sec(7'h51);
    plain_set();
    sts(OK);
    chk("pulses", 32'h1, 32'(pulses));
    u_sma_host.wr(`SMA_OFS_INT_STS, 32'h7);
    u_sma_host.cmd(8'h05, `SMA_CMD_SET_MAX);
    sts(AB);
    chk("irq_masked", 32'h0, {31'h0, irq_q});
    rd(`SMA_OFS_INT_STS);
    chk("abort_event", 32'h2, rv & 32'h2);
    u_sma_host.wr(`SMA_OFS_INT_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq_q});
    u_sma_host.wr(`SMA_OFS_INT_STS, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq_q});
    u_sma_host.cmd(`SMA_FEAT_FREEZE, `SMA_CMD_SET_MAX);
    sec(7'h54);
    for (int f = 1; f <= 3; f++) begin
      u_sma_host.cmd(8'(f), `SMA_CMD_SET_MAX);
      sts(AB);
    end
    plain_set();
    sts(AB);
    chk("pulses", 32'h1, 32'(pulses));
    summarize();
  end
endmodule // sma_max_addr_sec_tb

`default_nettype wire
